// ### mfcf_pkg.sv
// Package for the MAC frame control and filter block.
// Assumes a single 25 MHz clock and byte-wide frame streams.
package mfcf_pkg;
   // ******************************************
   // Register map
   // ******************************************
   localparam logic [15:0] MFCF_CTRL_ADDR     = 16'h0000;
   localparam logic [15:0] MFCF_FILT_BASE     = 16'h0010;
   localparam logic [15:0] MFCF_MASK_BASE     = 16'h0020;
   localparam logic [15:0] MFCF_TXSTAT_FIRST  = 16'h0030;
   localparam logic [15:0] MFCF_TXSTAT_LAST   = 16'h0040;
   localparam logic [15:0] MFCF_RXSTAT_FIRST  = 16'h0041;
   localparam logic [15:0] MFCF_RXDROP_ADDR   = 16'h0052;
   localparam int          MFCF_NUM_FILT      = 4;

   // ******************************************
   // Control register fields
   // ******************************************
   localparam int MFCF_BIT_CRC_BYPASS  = 19;
   localparam int MFCF_BIT_MCAST_DROP  = 18;
   localparam int MFCF_BIT_BCAST_DROP  = 17;
   localparam int MFCF_BIT_DEST_MATCH  = 16;
   localparam int MFCF_BIT_TX_CRC_INS  = 8;
   localparam int MFCF_BIT_TX_EN       = 1;
   localparam int MFCF_BIT_RX_EN       = 0;
   localparam int MFCF_BIT_FILT_EN     = 31;
   localparam logic [31:0] MFCF_CTRL_RESET = 32'h0000_0100;
   localparam logic [31:0] MFCF_CTRL_WMASK = 32'h003F_0103;

   // ******************************************
   // Frame constants
   // ******************************************
   localparam logic [6:0]  MFCF_MIN_PAYLOAD = 7'd60;
   localparam logic [31:0] MFCF_CRC_POLY    = 32'hEDB8_8320;
   localparam logic [31:0] MFCF_CRC_INIT    = 32'hFFFF_FFFF;
   localparam logic [31:0] MFCF_CRC_RESID   = 32'hDEBB_20E3;
   localparam int          MFCF_FIFO_DEPTH  = 32;
   localparam int          MFCF_FIFO_WIDTH  = 9;

   typedef enum logic [1:0] {
      MFCF_TX_IDLE,
      MFCF_TX_DATA,
      MFCF_TX_PAD,
      MFCF_TX_CRC
   } mfcf_tx_st_t;
endpackage

// ### mfcf_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; read data come from a register.
`timescale 1ns/10ps
module mfcf_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   input  wire logic             core_clk_i,
   input  wire logic             resetn_i,
   input  wire logic             clear_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   output logic      [WIDTH-1:0] out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      wr_q;
   logic [AW:0]      rd_q;
   logic             full;
   logic             empty;
   logic             push;
   logic             pop;

   // Pointer compare with wrap bit
   assign full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign empty = (wr_q == rd_q) && !out_valid_o;
   assign in_ready_o = !full;
   assign push = in_valid_i && !full;
   assign pop  = (wr_q != rd_q) && (!out_valid_o || out_ready_i);

   // Storage
   always_ff @(posedge core_clk_i) begin
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data_i;
      end
   end

   // Pointers and registered output stage
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_q        <= '0;
         rd_q        <= '0;
         out_valid_o <= 1'b0;
         out_data_o  <= '0;
      end else if (clear_i) begin
         wr_q        <= '0;
         rd_q        <= '0;
         out_valid_o <= 1'b0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q        <= rd_q + 1'b1;
            out_data_o  <= mem_q[rd_q[AW-1:0]];
            out_valid_o <= 1'b1;
         end else if (out_ready_i) begin
            out_valid_o <= 1'b0;
         end
      end
   end

   // Occupancy never exceeds depth
   fifo_bound_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      (wr_q - rd_q) <= (AW+1)'(DEPTH)) else $error("fifo overfilled");
   wire unused_empty = empty;
endmodule

// ### mfcf_core.sv
// MAC frame control: receive filters, transmit CRC/pad, path enables.
// Assumes byte streams from the PHY and host, host register port in words.
//
// Contract
// - Bypass bit set delivers frames even with bad CRC.
// - Delivered bad-CRC frame flags frame-drop in the receive footer.
// - Multicast drop discards frames whose group bit is one.
// - Broadcast frames escape the multicast filter; only broadcast bit decides.
// - Broadcast drop discards all-ones destination frames.
// - Multicast or broadcast discards increment the receive-dropped counter.
// - Destination match compares address against filter and mask registers.
// - Destination match clear means promiscuous acceptance.
// - A filter matches only if its enable and destination match set.
// - Insert bit set appends computed CRC to transmitted frames.
// - Insert bit clear sends host data with no added CRC.
// - Insert bit set pads short frames to 64 bytes.
// - Transmit enable forwards frames; clear holds them in buffer.
// - Transmit disable waits for the current frame to finish.
// - Clearing transmit enable resets transmit statistics counters.
// - Receive enable clear silently discards PHY frames.
// - Clearing receive enable resets receive statistics counters.
// - Receive disable mid-frame completes that frame.
// - Receive enable set mid-frame skips that frame.
`timescale 1ns/10ps
module mfcf_core (
   input  wire logic        core_clk_i,
   input  wire logic        resetn_i,
   // Register port
   input  wire logic [15:0] reg_addr_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   input  wire logic [31:0] reg_wdata_i,
   output logic      [31:0] reg_rdata_o,
   // Receive from PHY
   input  wire logic [7:0]  phy_rx_data_i,
   input  wire logic        phy_rx_valid_i,
   input  wire logic        phy_rx_last_i,
   // Receive to host
   output logic      [7:0]  host_rx_data_o,
   output logic             host_rx_valid_o,
   output logic             host_rx_last_o,
   output logic             host_rx_frame_drop_o,
   output logic             host_rx_abort_o,
   // Transmit from host
   input  wire logic [7:0]  host_tx_data_i,
   input  wire logic        host_tx_valid_i,
   input  wire logic        host_tx_last_i,
   output logic             host_tx_ready_o,
   // Transmit to PHY
   output logic      [7:0]  phy_tx_data_o,
   output logic             phy_tx_valid_o,
   output logic             phy_tx_last_o,
   input  wire logic        phy_tx_ready_i,
   // Statistics
   output logic      [31:0] rx_discard_count_o,
   output logic      [31:0] tx_frame_count_o
);
   import mfcf_pkg::*;

   // ******************************************
   // Registers
   // ******************************************
   logic [31:0] ctrl_q;
   logic [31:0] match_value_regs_q [2*MFCF_NUM_FILT];
   logic [31:0] match_mask_regs_q  [2*MFCF_NUM_FILT];
   logic [31:0] rx_discard_count_q;
   logic [31:0] tx_frame_count_q;
   logic        rx_en;
   logic        tx_en;
   logic        tx_en_fall;
   logic        rx_en_fall;

   assign rx_en = ctrl_q[MFCF_BIT_RX_EN];
   assign tx_en = ctrl_q[MFCF_BIT_TX_EN];
   assign tx_en_fall = reg_wr_i && reg_addr_i == MFCF_CTRL_ADDR && tx_en
                       && !reg_wdata_i[MFCF_BIT_TX_EN];
   assign rx_en_fall = reg_wr_i && reg_addr_i == MFCF_CTRL_ADDR && rx_en
                       && !reg_wdata_i[MFCF_BIT_RX_EN];

   // CRC-32 byte step, reflected
   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c ^ {24'h000000, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ MFCF_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // Control register, bits outside MFCF_CTRL_WMASK read zero
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_q <= MFCF_CTRL_RESET;
      end else if (reg_wr_i && reg_addr_i == MFCF_CTRL_ADDR) begin
         ctrl_q <= reg_wdata_i & MFCF_CTRL_WMASK;
      end
   end

   // Filter and mask words; high words keep only enable and 16 address bits
   for (genvar g = 0; g < 2*MFCF_NUM_FILT; g++) begin : g_filt
      localparam logic [31:0] WM = (g % 2 == 1) ? 32'h8000_FFFF : 32'hFFFF_FFFF;
      always_ff @(posedge core_clk_i or negedge resetn_i) begin
         if (!resetn_i) begin
            match_value_regs_q[g] <= '0;
            match_mask_regs_q[g]  <= '0;
         end else if (reg_wr_i) begin
            if (reg_addr_i == MFCF_FILT_BASE + 16'(g)) begin
               match_value_regs_q[g] <= reg_wdata_i & WM;
            end
            if (reg_addr_i == MFCF_MASK_BASE + 16'(g)) begin
               match_mask_regs_q[g] <= reg_wdata_i & WM;
            end
         end
      end
   end

   // Read mux, registered
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         reg_rdata_o <= '0;
      end else if (reg_rd_i) begin
         reg_rdata_o <= '0;
         if (reg_addr_i == MFCF_CTRL_ADDR) reg_rdata_o <= ctrl_q;
         if (reg_addr_i == MFCF_RXDROP_ADDR) reg_rdata_o <= rx_discard_count_q;
         if (reg_addr_i == MFCF_TXSTAT_FIRST) reg_rdata_o <= tx_frame_count_q;
         for (int k = 0; k < 2*MFCF_NUM_FILT; k++) begin
            if (reg_addr_i == MFCF_FILT_BASE + 16'(k)) reg_rdata_o <= match_value_regs_q[k];
            if (reg_addr_i == MFCF_MASK_BASE + 16'(k)) reg_rdata_o <= match_mask_regs_q[k];
         end
      end
   end

   // ******************************************
   // Receive path
   // ******************************************
   logic        rx_busy_q;     // Inside a PHY frame
   logic        rx_take_q;     // Current frame is being passed on
   logic [2:0]  rx_idx_q;
   logic [47:0] rx_da_q;
   logic [31:0] rx_crc_q;
   logic        rx_first;
   logic [47:0] da_now;
   logic        rx_mcast;
   logic        rx_bcast;
   logic        rx_addr_ok;
   logic        rx_crc_bad;
   logic        rx_drop_cast;
   logic        rx_crc_discard;
   logic [31:0] rx_crc_next;

   assign rx_first    = phy_rx_valid_i && !rx_busy_q;
   assign rx_crc_next = crc_step(rx_first ? MFCF_CRC_INIT : rx_crc_q, phy_rx_data_i);
   assign da_now      = rx_da_q;
   assign rx_mcast    = da_now[0];
   assign rx_bcast    = &da_now;
   assign rx_crc_bad  = rx_crc_next != MFCF_CRC_RESID;

   // Address match over enabled filters
   always_comb begin
      rx_addr_ok = !ctrl_q[MFCF_BIT_DEST_MATCH];
      for (int f = 0; f < MFCF_NUM_FILT; f++) begin
         if (ctrl_q[MFCF_BIT_DEST_MATCH] && match_value_regs_q[2*f+1][MFCF_BIT_FILT_EN]
             && ((da_now ^ {match_value_regs_q[2*f+1][15:0], match_value_regs_q[2*f]})
                 & {match_mask_regs_q[2*f+1][15:0], match_mask_regs_q[2*f]}) == 48'h0) begin
            rx_addr_ok = 1'b1;
         end
      end
   end

   // Broadcast ruled only by its own bit
   assign rx_drop_cast = (rx_bcast && ctrl_q[MFCF_BIT_BCAST_DROP])
                      || (rx_mcast && !rx_bcast && ctrl_q[MFCF_BIT_MCAST_DROP]);
   assign rx_crc_discard = rx_crc_bad && !ctrl_q[MFCF_BIT_CRC_BYPASS];

   // Receive buffer: taken bytes stream through at once; the filter decides at frame end
   logic [8:0] rxf_in;
   logic       rxf_push;
   logic [8:0] rxf_out;
   logic       rxf_valid;
   logic       rxf_ready;

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rx_busy_q <= 1'b0;
         rx_take_q <= 1'b0;
         rx_idx_q  <= '0;
         rx_da_q   <= '0;
         rx_crc_q  <= MFCF_CRC_INIT;
      end else if (phy_rx_valid_i) begin
         rx_crc_q <= rx_crc_next;
         if (rx_first) begin
            rx_busy_q <= !phy_rx_last_i;
            rx_take_q <= rx_en;              // Enabled mid-frame: skip
            rx_idx_q  <= 3'd1;
            rx_da_q   <= {40'h0, phy_rx_data_i};
         end else begin
            if (rx_idx_q < 3'd6) begin
               rx_da_q[8*rx_idx_q +: 8] <= phy_rx_data_i;
               rx_idx_q <= rx_idx_q + 3'd1;
            end
            if (phy_rx_last_i) begin
               rx_busy_q <= 1'b0;           // Disable mid-frame does not cut it
            end
         end
      end
   end

   // Stream bytes through; the whole frame is decided at its end
   assign rxf_in   = {phy_rx_last_i, phy_rx_data_i};
   assign rxf_push = phy_rx_valid_i && (rx_first ? rx_en : rx_take_q);
   assign rxf_ready = 1'b1;

   mfcf_fifo #(.WIDTH(MFCF_FIFO_WIDTH), .DEPTH(MFCF_FIFO_DEPTH)) u_rx_fifo (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .clear_i    (1'b0),
      .in_data_i  (rxf_in),
      .in_valid_i (rxf_push),
      .in_ready_o (),
      .out_data_o (rxf_out),
      .out_valid_o(rxf_valid),
      .out_ready_i(rxf_ready)
   );

   // Host side sees end-of-frame status one cycle before the last byte; aborted frames are flagged
   logic rx_end;
   assign rx_end = phy_rx_valid_i && phy_rx_last_i && !rx_first && rx_take_q;
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         host_rx_frame_drop_o <= 1'b0;
         host_rx_abort_o      <= 1'b0;
      end else begin
         host_rx_frame_drop_o <= rx_end && rx_crc_bad && !rx_crc_discard;
         host_rx_abort_o      <= rx_end && (rx_crc_discard || rx_drop_cast || !rx_addr_ok);
      end
   end
   assign host_rx_data_o  = rxf_out[7:0];
   assign host_rx_valid_o = rxf_valid;
   assign host_rx_last_o  = rxf_valid && rxf_out[8];

   // Receive-dropped counter, cleared when receive is disabled
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rx_discard_count_q <= '0;
      end else if (rx_en_fall) begin
         rx_discard_count_q <= '0;
      end else if (rx_end && rx_drop_cast) begin
         rx_discard_count_q <= rx_discard_count_q + 32'd1;
      end
   end
   assign rx_discard_count_o = rx_discard_count_q;

   // ******************************************
   // Transmit path
   // ******************************************
   mfcf_tx_st_t tx_st_q;
   logic [6:0]  tx_len_q;
   logic [31:0] tx_crc_q;
   logic [1:0]  tx_crc_idx_q;
   logic        tx_ins;
   logic        tx_go;

   assign tx_ins = ctrl_q[MFCF_BIT_TX_CRC_INS];
   assign tx_go  = phy_tx_ready_i;
   // Disabled: host frames stay buffered upstream
   assign host_tx_ready_o = (tx_st_q == MFCF_TX_DATA) && tx_go;

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tx_st_q      <= MFCF_TX_IDLE;
         tx_len_q     <= '0;
         tx_crc_q     <= MFCF_CRC_INIT;
         tx_crc_idx_q <= '0;
      end else begin
         case (tx_st_q)
            MFCF_TX_IDLE: begin
               if (tx_en && host_tx_valid_i) begin
                  tx_st_q  <= MFCF_TX_DATA;
                  tx_len_q <= '0;
                  tx_crc_q <= MFCF_CRC_INIT;
               end
            end
            // Enable is not looked at again until idle
            MFCF_TX_DATA: begin
               if (host_tx_valid_i && tx_go) begin
                  tx_crc_q <= crc_step(tx_crc_q, host_tx_data_i);
                  if (tx_len_q != 7'h7F) tx_len_q <= tx_len_q + 7'd1;
                  if (host_tx_last_i) begin
                     tx_crc_idx_q <= '0;
                     if (!tx_ins) tx_st_q <= MFCF_TX_IDLE;
                     else if (tx_len_q + 7'd1 < MFCF_MIN_PAYLOAD) tx_st_q <= MFCF_TX_PAD;
                     else tx_st_q <= MFCF_TX_CRC;
                  end
               end
            end
            MFCF_TX_PAD: begin
               if (tx_go) begin
                  tx_crc_q <= crc_step(tx_crc_q, 8'h00);
                  tx_len_q <= tx_len_q + 7'd1;
                  if (tx_len_q + 7'd1 >= MFCF_MIN_PAYLOAD) tx_st_q <= MFCF_TX_CRC;
               end
            end
            MFCF_TX_CRC: begin
               if (tx_go) begin
                  tx_crc_idx_q <= tx_crc_idx_q + 2'd1;
                  if (tx_crc_idx_q == 2'd3) tx_st_q <= MFCF_TX_IDLE;
               end
            end
            default: tx_st_q <= MFCF_TX_IDLE;
         endcase
      end
   end

   // PHY side byte mux
   logic [31:0] crc_out;
   assign crc_out = ~tx_crc_q;
   always_comb begin
      phy_tx_valid_o = 1'b0;
      phy_tx_data_o  = 8'h00;
      phy_tx_last_o  = 1'b0;
      case (tx_st_q)
         MFCF_TX_DATA: begin
            phy_tx_valid_o = host_tx_valid_i;
            phy_tx_data_o  = host_tx_data_i;
            phy_tx_last_o  = host_tx_last_i && !tx_ins;
         end
         MFCF_TX_PAD: phy_tx_valid_o = 1'b1;
         MFCF_TX_CRC: begin
            phy_tx_valid_o = 1'b1;
            phy_tx_data_o  = crc_out[8*tx_crc_idx_q +: 8];
            phy_tx_last_o  = tx_crc_idx_q == 2'd3;
         end
         default: phy_tx_valid_o = 1'b0;
      endcase
   end

   // Transmit frame counter, cleared when transmit is disabled
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tx_frame_count_q <= '0;
      end else if (tx_en_fall) begin
         tx_frame_count_q <= '0;
      end else if (phy_tx_valid_o && phy_tx_last_o && tx_go) begin
         tx_frame_count_q <= tx_frame_count_q + 32'd1;
      end
   end
   assign tx_frame_count_o = tx_frame_count_q;

   // ******************************************
   // Checks
   // ******************************************
   tx_idle_hold_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      (tx_st_q == MFCF_TX_IDLE && !tx_en) |=> tx_st_q == MFCF_TX_IDLE)
      else $error("tx left idle while disabled");
   // Stalls stretch the CRC bytes, so check each step instead of a fixed span
   tx_crc_len_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      (tx_st_q == MFCF_TX_CRC && tx_go) |=> (tx_crc_idx_q == $past(tx_crc_idx_q) + 2'd1)
         && ((tx_st_q == MFCF_TX_IDLE) == (tx_crc_idx_q == 2'd0)))
      else $error("crc not four bytes");
   tx_pad_min_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      (tx_st_q == MFCF_TX_PAD) ##1 (tx_st_q == MFCF_TX_CRC) |-> tx_len_q >= MFCF_MIN_PAYLOAD)
      else $error("short frame not padded");
   tx_no_crc_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      !tx_ins |-> (tx_st_q != MFCF_TX_PAD && tx_st_q != MFCF_TX_CRC) || $changed(tx_ins))
      else $error("crc added while insert off");
   rx_off_quiet_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      (rx_first && !rx_en) |-> !rxf_push)
      else $error("frame taken while rx off");
   rx_skip_mid_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      (rx_busy_q && !rx_take_q && phy_rx_valid_i) |-> !rxf_push)
      else $error("partial frame passed");
   rx_drop_cnt_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      (rx_end && rx_drop_cast && !rx_en_fall)
         |=> rx_discard_count_q == $past(rx_discard_count_q) + 32'd1)
      else $error("drop not counted");
   rx_bcast_mc_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      (rx_bcast && !ctrl_q[MFCF_BIT_BCAST_DROP]) |-> !rx_drop_cast)
      else $error("broadcast dropped by multicast");
   rx_crc_flag_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      (rx_end && rx_crc_bad && ctrl_q[MFCF_BIT_CRC_BYPASS])
         |=> (host_rx_frame_drop_o && !host_rx_abort_o) || $past(rx_drop_cast || !rx_addr_ok))
      else $error("bad crc not flagged");
   rx_stat_clr_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      rx_en_fall |=> rx_discard_count_q == 32'd0)
      else $error("rx stats not cleared");
endmodule

// ### mfcf_phy_model.sv
// PHY stand-in: plays receive frames and takes transmit bytes with stalls.
// Assumes the bench fills fr before calling rx_frame.
`timescale 1ns/10ps
module mfcf_phy_model (
   input  wire logic       core_clk_i,
   output logic      [7:0] rx_data_o,
   output logic            rx_valid_o,
   output logic            rx_last_o,
   input  wire logic [7:0] tx_data_i,
   input  wire logic       tx_valid_i,
   input  wire logic       tx_last_i,
   output logic            tx_ready_o
);
   logic [7:0] fr [64];
   logic [7:0] txb [64];
   int         tx_n = 0;
   logic [1:0] cyc_q = 2'h0;
   initial begin
      rx_data_o = 8'h00;
      rx_valid_o = 1'b0;
      rx_last_o = 1'b0;
   end
   // Stall every fourth cycle so the sender must hold its bytes
   assign tx_ready_o = (cyc_q != 2'h3);
   always_ff @(posedge core_clk_i) begin
      cyc_q <= cyc_q + 2'h1;
      if (tx_valid_i && tx_ready_o) begin
         txb[tx_n[5:0]] <= tx_data_i;
         tx_n <= tx_n + 1;
      end
   end
   // One frame, last byte marked; idle data then shows junk, not the last byte
   task automatic rx_frame(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge core_clk_i);
         rx_data_o <= fr[i];
         rx_valid_o <= 1'b1;
         rx_last_o <= (i == n - 1);
      end
      @(posedge core_clk_i);
      rx_data_o <= ~rx_data_o;
      rx_valid_o <= 1'b0;
      rx_last_o <= 1'b0;
   endtask
endmodule

// ### testbench.sv
// Bench for the frame control block: registers, receive filters, transmit.
// Assumes the design sources and the PHY stand-in are compiled first.
`timescale 1ns/10ps
module testbench;
   import mfcf_pkg::*;
   logic        clk = 1'b0, rstn = 1'b0, rw = 1'b0, rr = 1'b0;
   logic [15:0] ra = 16'h0;
   logic [31:0] wd = 32'h0, rdat, disc, c, tfc;
   logic [7:0]  prd, htd = 8'h0, ptd, hrd, lsb = 8'h0;
   logic        prv, prl, hrv, hrl, hfd, hab, htv = 1'b0, htl = 1'b0, hty, ptv, ptl, pty;
   logic [7:0]  fb [64];
   int          bad_count = 0, check_count = 0, rxb = 0, abn = 0, fdn = 0;
   mfcf_core i_dut (
      .core_clk_i(clk), .resetn_i(rstn), .reg_addr_i(ra), .reg_wr_i(rw), .reg_rd_i(rr),
      .reg_wdata_i(wd), .reg_rdata_o(rdat), .phy_rx_data_i(prd), .phy_rx_valid_i(prv),
      .phy_rx_last_i(prl), .host_rx_data_o(hrd), .host_rx_valid_o(hrv), .host_rx_last_o(hrl),
      .host_rx_frame_drop_o(hfd), .host_rx_abort_o(hab), .host_tx_data_i(htd),
      .host_tx_valid_i(htv), .host_tx_last_i(htl), .host_tx_ready_o(hty),
      .phy_tx_data_o(ptd), .phy_tx_valid_o(ptv), .phy_tx_last_o(ptl), .phy_tx_ready_i(pty),
      .rx_discard_count_o(disc), .tx_frame_count_o(tfc));
   mfcf_phy_model i_phy (.core_clk_i(clk), .rx_data_o(prd), .rx_valid_o(prv),
      .rx_last_o(prl), .tx_data_i(ptd), .tx_valid_i(ptv), .tx_last_i(ptl), .tx_ready_o(pty));
   // ******
   // Clock, watchdog and host-side monitor
   // ******
   initial forever #20 clk = ~clk;
   initial begin
      #1000000;
      bad_count++;
      stop_test();
   end
   always @(posedge clk) begin
      if (hrv === 1'b1) rxb <= rxb + 1;
      if (hab === 1'b1) abn <= abn + 1;
      if (hfd === 1'b1) fdn <= fdn + 1;
      if (hrv === 1'b1 && hrl === 1'b1) lsb <= hrd;
   end
   // ******
   // Tasks
   // ******
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      ra <= a;
      wd <= d;
      rw <= 1'b1;
      @(posedge clk);
      rw <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [31:0] d);
      @(posedge clk);
      ra <= a;
      rr <= 1'b1;
      @(posedge clk);
      rr <= 1'b0;
      #1 d = rdat;
   endtask
   // Reflected CRC over fb, kept apart from the design's own code
   function automatic logic [31:0] crc_of(input int n);
      logic [31:0] x;
      x = MFCF_CRC_INIT;
      for (int i = 0; i < n; i++) begin
         x = x ^ {24'h0, fb[i]};
         for (int k = 0; k < 8; k++) x = x[0] ? (x >> 1) ^ MFCF_CRC_POLY : x >> 1;
      end
      return ~x;
   endfunction
   // Frame with all destination bytes equal to da; eb < 0 skips the byte count
   task automatic rx(input logic [7:0] da, input logic good, input int eb, ea, ef);
      int b0, a0, f0;
      b0 = rxb;
      a0 = abn;
      f0 = fdn;
      for (int i = 0; i < 60; i++) fb[i] = (i < 6) ? da : i[7:0];
      c = crc_of(60) ^ {31'h0, !good};
      for (int i = 0; i < 4; i++) fb[60 + i] = c[8 * i +: 8];
      i_phy.fr = fb;
      i_phy.rx_frame(64);
      repeat (8) @(posedge clk);
      if (eb >= 0) chk(32'(rxb - b0), 32'(eb));
      // Delivered frame ends on its own final byte, marked last
      if (eb > 0) chk({24'h0, lsb}, {24'h0, fb[63]});
      chk(32'(abn - a0), 32'(ea));
      chk(32'(fdn - f0), 32'(ef));
   endtask
   // Control write lands ten cycles into a frame
   task automatic rx_mid(input logic [31:0] ctl, input int eb);
      int b0;
      b0 = rxb;
      fork
         i_phy.rx_frame(64);
         begin
            repeat (10) @(posedge clk);
            wr(MFCF_CTRL_ADDR, ctl);
         end
      join
      repeat (8) @(posedge clk);
      chk(32'(rxb - b0), 32'(eb));
   endtask
   // Host bytes held until ready is seen high at a falling edge
   task automatic tx_send(input int n);
      logic r;
      for (int i = 0; i < n; i++) begin
         htd <= fb[i];
         htv <= 1'b1;
         htl <= (i == n - 1);
         do begin
            @(negedge clk);
            r = hty;
            @(posedge clk);
         end while (r !== 1'b1);
      end
      htv <= 1'b0;
      htl <= 1'b0;
   endtask
   task automatic tx_wait(input int n);
      for (int k = 0; k < 400 && i_phy.tx_n < n; k++) @(posedge clk);
      repeat (4) @(posedge clk);
      chk(32'(i_phy.tx_n), 32'(n));
   endtask
   // ******
   // Main sequence
   // ******
   initial begin
      logic [31:0] d;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      rd(MFCF_CTRL_ADDR, d);
      chk(d, MFCF_CTRL_RESET);
      rd(16'h0FFF, d);
      chk(d, 32'h0);
      rx(8'h02, 1'b1, 0, 0, 0);
      wr(MFCF_CTRL_ADDR, 32'h0000_0101);
      rx(8'h02, 1'b0, -1, 1, 0);
      wr(MFCF_CTRL_ADDR, 32'h0008_0101);
      rx(8'h02, 1'b0, 64, 0, 1);
      wr(MFCF_CTRL_ADDR, 32'h0004_0101);
      rx(8'h01, 1'b1, -1, 1, 0);
      rx(8'hFF, 1'b1, 64, 0, 0);
      wr(MFCF_CTRL_ADDR, 32'h0002_0101);
      rx(8'hFF, 1'b1, -1, 1, 0);
      rd(MFCF_RXDROP_ADDR, d);
      chk(d, 32'h2);
      chk(disc, 32'h2);
      wr(MFCF_FILT_BASE, 32'h0202_0202);
      wr(MFCF_MASK_BASE, 32'hFFFF_FFFF);
      wr(MFCF_MASK_BASE + 16'h1, 32'h0000_FFFF);
      wr(MFCF_CTRL_ADDR, 32'h0001_0101);
      rx(8'h02, 1'b1, -1, 1, 0);
      wr(MFCF_FILT_BASE + 16'h1, 32'h8000_0202);
      rx(8'h02, 1'b1, 64, 0, 0);
      rx(8'h04, 1'b1, -1, 1, 0);
      wr(MFCF_CTRL_ADDR, 32'h0000_0101);
      rx(8'h04, 1'b1, 64, 0, 0);
      rx_mid(32'h0000_0100, 64);
      rd(MFCF_RXDROP_ADDR, d);
      chk(d, 32'h0);
      rx_mid(32'h0000_0101, 0);
      for (int i = 0; i < 64; i++) fb[i] = (i < 10) ? 8'hA0 + i[7:0] : 8'h00;
      c = crc_of(60);
      fork
         tx_send(10);
         begin
            repeat (10) @(posedge clk);
            chk(32'(i_phy.tx_n), 32'h0);
            wr(MFCF_CTRL_ADDR, 32'h0000_0103);
         end
      join
      tx_wait(64);
      chk({i_phy.txb[63], i_phy.txb[62], i_phy.txb[61], i_phy.txb[60]}, c);
      for (int i = 0; i < 4; i++) fb[60 + i] = c[8 * i +: 8];
      wr(MFCF_CTRL_ADDR, 32'h0000_0003);
      tx_send(64);
      tx_wait(128);
      rd(MFCF_TXSTAT_FIRST, d);
      chk(d, 32'h2);
      chk(tfc, 32'h2);
      fork
         tx_send(64);
         begin
            repeat (20) @(posedge clk);
            wr(MFCF_CTRL_ADDR, 32'h0000_0000);
            // Read while the frame is still going out
            rd(MFCF_TXSTAT_FIRST, d);
            chk(d, 32'h0);
         end
      join
      tx_wait(192);
      // The frame that finishes after the clear counts afresh
      rd(MFCF_TXSTAT_FIRST, d);
      chk(d, 32'h1);
      chk(tfc, 32'h1);
      stop_test();
   end
endmodule
